// [hw/bce_pkg.sv]
// Shared constants, types and helpers of the branch, call and compare execution block.
package bce_pkg;

  localparam int XLEN = 32;
  localparam int RIDX_W = 5;
  localparam int NREGS = 32;
  localparam int OP_W = 6;
  localparam int ADDR_W = 8;
  localparam int STRB_W = 4;

  // Instruction field positions.
  localparam int F_A_LSB = 27;
  localparam int F_B_LSB = 22;
  localparam int F_C_LSB = 17;
  localparam int F_OPX_LSB = 11;
  localparam int F_IMM_LSB = 6;
  localparam int F_OP_LSB = 0;
  localparam int HALF_IMM_W = 16;
  localparam int JMP_IMM_W = 26;
  localparam int PC_REGION_LSB = 28;

  // Primary and extended opcodes.
  localparam logic [OP_W-1:0] OP_RTYPE = 6'h3a;
  localparam logic [OP_W-1:0] OP_BNE = 6'h1e;
  localparam logic [OP_W-1:0] OP_RELJMP = 6'h06;
  localparam logic [OP_W-1:0] OP_CALL = 6'h00;
  localparam logic [OP_W-1:0] OPX_BREAK = 6'h34;
  localparam logic [OP_W-1:0] OPX_BRET = 6'h09;
  localparam logic [OP_W-1:0] OPX_CALLR = 6'h1d;
  localparam logic [OP_W-1:0] OPX_CMPEQ = 6'h20;
  localparam logic [OP_W-1:0] OPX_CMPGE = 6'h08;

  localparam logic [RIDX_W-1:0] ZERO_IDX = 5'h00;
  localparam logic [RIDX_W-1:0] BA_IDX = 5'h1e;
  localparam logic [RIDX_W-1:0] RETADDR_IDX = 5'h1f;

  localparam logic [XLEN-1:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [XLEN-1:0] PC_RST = 32'h0000_0000;

  // Register map, byte addresses.
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BSTATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EXEC = 8'h10;
  localparam int GPR_SEL_BIT = 7;

  // Status layout.
  localparam int STATUS_W = 2;
  localparam int ST_IRQ_EN = 0;
  localparam int ST_U = 1;
  localparam logic [STATUS_W-1:0] STATUS_RST = 2'h0;

  // Execution status layout.
  localparam int EX_UNSUP = 0;
  localparam int EX_TAKEN = 1;
  localparam int EX_CNT_LSB = 8;
  localparam int EX_CNT_W = 8;

  typedef enum logic [3:0] {
    BCE_NONE = 4'h0,
    BCE_BNE = 4'h1,
    BCE_RELJMP = 4'h2,
    BCE_BREAK = 4'h3,
    BCE_BRET = 4'h4,
    BCE_CALL = 4'h5,
    BCE_CALLR = 4'h6,
    BCE_CMPEQ = 4'h7,
    BCE_CMPEQI = 4'h8,
    BCE_CMPGE = 4'h9,
    BCE_CMPGEI = 4'ha
  } bce_op_t;

  function automatic logic [XLEN-1:0] bce_sext16(input logic [HALF_IMM_W-1:0] imm);
    return {{(XLEN-HALF_IMM_W){imm[HALF_IMM_W-1]}}, imm};
  endfunction

  function automatic logic [XLEN-1:0] bce_rel_target(input logic [XLEN-1:0] pc, input logic [HALF_IMM_W-1:0] imm);
    return pc + INSTR_STEP + bce_sext16(imm);
  endfunction

endpackage

// [hw/bce_dec_if.sv]
// Decoded instruction fields passed from the decoder to the execution logic.
`timescale 1ns/100ps
`default_nettype none
interface bce_dec_if;
  import bce_pkg::*;
  logic [XLEN-1:0] instr;
  bce_op_t op;
  logic [RIDX_W-1:0] idx_a;
  logic [RIDX_W-1:0] idx_b;
  logic [RIDX_W-1:0] idx_c;
  logic [HALF_IMM_W-1:0] half_imm;
  logic [JMP_IMM_W-1:0] jmp_imm;
  modport dec (input instr, output op, output idx_a, output idx_b, output idx_c, output half_imm, output jmp_imm);
  modport exe (output instr, input op, input idx_a, input idx_b, input idx_c, input half_imm, input jmp_imm);
endinterface
`default_nettype wire

// [hw/bce_decoder.sv]
// Instruction decoder for the branch, call and compare subset.
`timescale 1ns/100ps
`default_nettype none
module bce_decoder import bce_pkg::*; #(
  parameter logic [OP_W-1:0] OP_CMPEQI_CODE = 6'h20,
  parameter logic [OP_W-1:0] OP_CMPGEI_CODE = 6'h08
) (
  bce_dec_if.dec d
);
  logic [OP_W-1:0] opc;
  logic [OP_W-1:0] opx;

  assign opc = d.instr[F_OP_LSB +: OP_W];
  assign opx = d.instr[F_OPX_LSB +: OP_W];
  assign d.idx_a = d.instr[F_A_LSB +: RIDX_W]; // see RULE16 see RULE17
  assign d.idx_b = d.instr[F_B_LSB +: RIDX_W]; // see RULE16 see RULE17
  assign d.idx_c = d.instr[F_C_LSB +: RIDX_W];
  assign d.half_imm = d.instr[F_IMM_LSB +: HALF_IMM_W]; // see RULE17
  assign d.jmp_imm = d.instr[F_IMM_LSB +: JMP_IMM_W];

  // The 5-bit debugger tag field is never looked at, so any tag decodes the same trap.
  always_comb begin
    d.op = BCE_NONE;
    if (opc == OP_RTYPE) begin
      case (opx)
        OPX_BREAK: d.op = BCE_BREAK; // see RULE4 see RULE6
        OPX_BRET: d.op = BCE_BRET; // see RULE8
        OPX_CALLR: d.op = BCE_CALLR; // see RULE11
        OPX_CMPEQ: d.op = BCE_CMPEQ; // see RULE12
        OPX_CMPGE: d.op = BCE_CMPGE; // see RULE14
        default: d.op = BCE_NONE;
      endcase
    end else if (opc == OP_BNE) begin
      d.op = BCE_BNE; // see RULE1
    end else if (opc == OP_RELJMP) begin
      d.op = BCE_RELJMP; // see RULE3
    end else if (opc == OP_CALL) begin
      d.op = BCE_CALL; // see RULE9
    end else if (opc == OP_CMPEQI_CODE) begin
      d.op = BCE_CMPEQI; // see RULE13
    end else if (opc == OP_CMPGEI_CODE) begin
      d.op = BCE_CMPGEI; // see RULE15
    end
  end
endmodule
`default_nettype wire

// [hw/bce_compare.sv]
// Equality and two's complement greater-or-equal comparator.
`timescale 1ns/100ps
`default_nettype none
module bce_compare #(
  parameter int W = 32
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic eq_o,
  output logic sge_o
);
  assign eq_o = (a_i == b_i);
  assign sge_o = ($signed(a_i) >= $signed(b_i)); // see RULE14 see RULE15
endmodule
`default_nettype wire

// [hw/bce_exec_top.sv]
// APB-reached execution unit for branches, calls, debug trap and compares.
//
// How it works
// RULE1 - Not-equal branch taken when sources differ.
// RULE2 - Offset is signed bytes from next instruction.
// RULE3 - Unconditional branch always jumps relative.
// RULE4 - Trap saves status and next address.
// RULE5 - Trap clears interrupt enable, user, jumps handler.
// RULE6 - Trap ignores its debugger tag field.
// RULE7 - Handler address is a build-time constant.
// RULE8 - Breakpoint return restores status, jumps saved address.
// RULE9 - Direct call links and jumps within region.
// RULE10 - Direct call reaches only current 256 MB region.
// RULE11 - Indirect call links and jumps to register.
// RULE12 - Register equality compare writes one or zero.
// RULE13 - Immediate equality compare uses sign-extended immediate.
// RULE14 - Register signed greater-or-equal compare.
// RULE15 - Immediate signed greater-or-equal compare.
// RULE16 - Register fields select operands and destination.
// RULE17 - Field placement of indices, immediate, opcode.
`timescale 1ns/100ps
`default_nettype none
module bce_exec_top import bce_pkg::*; #(
  parameter logic [XLEN-1:0] BREAK_HANDLER_ADDR = 32'h0000_0020,
  parameter logic [OP_W-1:0] OP_CMPEQI_CODE = 6'h20,
  parameter logic [OP_W-1:0] OP_CMPGEI_CODE = 6'h08
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [XLEN-1:0] pwdata_i,
  input wire logic [STRB_W-1:0] pstrb_i,
  output logic [XLEN-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  bce_dec_if dec ();

  logic [XLEN-1:0] gpr_r [NREGS];
  logic [XLEN-1:0] pc_r;
  logic [XLEN-1:0] pc_nxt;
  logic [XLEN-1:0] instr_r;
  logic [STATUS_W-1:0] status_r;
  logic [STATUS_W-1:0] status_nxt;
  logic [STATUS_W-1:0] bstatus_r;
  logic [STATUS_W-1:0] bstatus_nxt;
  logic go_r;
  logic unsup_r;
  logic taken_r;
  logic [EX_CNT_W-1:0] exec_cnt_r;

  logic [XLEN-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic apb_access;
  logic apb_capture;
  logic apb_fire;
  logic wr_fire;
  logic addr_ok;
  logic addr_gpr;
  logic [RIDX_W-1:0] addr_gpr_idx;
  logic [XLEN-1:0] rd_mux;

  logic [XLEN-1:0] rd_a;
  logic [XLEN-1:0] rd_b;
  logic [XLEN-1:0] cmp_b;
  logic cmp_eq;
  logic cmp_sge;
  logic [XLEN-1:0] seq_pc;
  logic res_we;
  logic [RIDX_W-1:0] res_idx;
  logic [XLEN-1:0] res_data;
  logic res_taken;
  logic res_unsup;

  // Register zero always reads as zero, so a destination of zero discards the result.
  function automatic logic [XLEN-1:0] gpr_read(input logic [RIDX_W-1:0] idx);
    logic [XLEN-1:0] v;
    v = '0;
    if (idx != ZERO_IDX) begin
      v = gpr_r[idx];
    end
    return v;
  endfunction

  function automatic logic [XLEN-1:0] merge_strb(input logic [XLEN-1:0] old_v, input logic [XLEN-1:0] new_v,
                                                 input logic [STRB_W-1:0] strb);
    logic [XLEN-1:0] v;
    v = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic [XLEN-1:0] flag_word(input logic f);
    return {{(XLEN-1){1'b0}}, f};
  endfunction

  bce_decoder #(
    .OP_CMPEQI_CODE(OP_CMPEQI_CODE),
    .OP_CMPGEI_CODE(OP_CMPGEI_CODE)
  ) u_dec (
    .d(dec.dec)
  );

  assign dec.instr = instr_r;

  always_comb rd_a = gpr_read(dec.idx_a); // see RULE16
  always_comb rd_b = gpr_read(dec.idx_b); // see RULE16

  // Immediate compares take the sign-extended immediate in place of the second register.
  always_comb begin
    cmp_b = rd_b;
    if (dec.op == BCE_CMPEQI || dec.op == BCE_CMPGEI) begin
      cmp_b = bce_sext16(dec.half_imm); // see RULE13 see RULE15
    end
  end

  bce_compare #(
    .W(XLEN)
  ) u_cmp (
    .a_i(rd_a),
    .b_i(cmp_b),
    .eq_o(cmp_eq),
    .sge_o(cmp_sge)
  );

  assign seq_pc = pc_r + INSTR_STEP;

  // One instruction executes in the cycle after its word is written.
  always_comb begin
    pc_nxt = pc_r;
    status_nxt = status_r;
    bstatus_nxt = bstatus_r;
    res_we = 1'b0;
    res_idx = ZERO_IDX;
    res_data = '0;
    res_taken = 1'b0;
    res_unsup = 1'b0;
    if (go_r) begin
      pc_nxt = seq_pc;
      case (dec.op)
        BCE_BNE: begin
          if (!cmp_eq) begin
            pc_nxt = bce_rel_target(pc_r, dec.half_imm); // see RULE1 see RULE2
            res_taken = 1'b1;
          end
        end
        BCE_RELJMP: begin
          pc_nxt = bce_rel_target(pc_r, dec.half_imm); // see RULE3 see RULE2
          res_taken = 1'b1;
        end
        BCE_BREAK: begin
          bstatus_nxt = status_r; // see RULE4
          res_we = 1'b1;
          res_idx = BA_IDX;
          res_data = seq_pc; // see RULE4
          status_nxt[ST_IRQ_EN] = 1'b0; // see RULE5
          status_nxt[ST_U] = 1'b0; // see RULE5
          pc_nxt = BREAK_HANDLER_ADDR; // see RULE5 see RULE7
          res_taken = 1'b1;
        end
        BCE_BRET: begin
          status_nxt = bstatus_r; // see RULE8
          pc_nxt = gpr_read(BA_IDX); // see RULE8
          res_taken = 1'b1;
        end
        BCE_CALL: begin
          res_we = 1'b1;
          res_idx = RETADDR_IDX;
          res_data = seq_pc; // see RULE9
          // The upper bits are kept, so a target outside the current region cannot be formed.
          pc_nxt = {pc_r[XLEN-1:PC_REGION_LSB], dec.jmp_imm, WORD_ALIGN}; // see RULE9 see RULE10
          res_taken = 1'b1;
        end
        BCE_CALLR: begin
          res_we = 1'b1;
          res_idx = RETADDR_IDX;
          res_data = seq_pc; // see RULE11
          pc_nxt = rd_a; // see RULE11
          res_taken = 1'b1;
        end
        BCE_CMPEQ: begin
          res_we = 1'b1;
          res_idx = dec.idx_c;
          res_data = flag_word(cmp_eq); // see RULE12
        end
        BCE_CMPEQI: begin
          res_we = 1'b1;
          res_idx = dec.idx_b; // see RULE16
          res_data = flag_word(cmp_eq); // see RULE13
        end
        BCE_CMPGE: begin
          res_we = 1'b1;
          res_idx = dec.idx_c;
          res_data = flag_word(cmp_sge); // see RULE14
        end
        BCE_CMPGEI: begin
          res_we = 1'b1;
          res_idx = dec.idx_b; // see RULE16
          res_data = flag_word(cmp_sge); // see RULE15
        end
        default: begin
          res_unsup = 1'b1;
        end
      endcase
    end
  end

  // APB address decode.
  assign addr_gpr = paddr_i[GPR_SEL_BIT];
  assign addr_gpr_idx = paddr_i[2 +: RIDX_W];

  always_comb begin
    addr_ok = 1'b0;
    rd_mux = '0;
    if (paddr_i[1:0] == WORD_ALIGN) begin
      if (addr_gpr) begin
        addr_ok = 1'b1;
        rd_mux = gpr_read(addr_gpr_idx);
      end else begin
        case (paddr_i)
          OFF_INSTR: begin
            addr_ok = 1'b1;
            rd_mux = instr_r;
          end
          OFF_PC: begin
            addr_ok = 1'b1;
            rd_mux = pc_r;
          end
          OFF_STATUS: begin
            addr_ok = 1'b1;
            rd_mux[STATUS_W-1:0] = status_r;
          end
          OFF_BSTATUS: begin
            addr_ok = 1'b1;
            rd_mux[STATUS_W-1:0] = bstatus_r;
          end
          OFF_EXEC: begin
            addr_ok = 1'b1;
            rd_mux[EX_UNSUP] = unsup_r;
            rd_mux[EX_TAKEN] = taken_r;
            rd_mux[EX_CNT_LSB +: EX_CNT_W] = exec_cnt_r;
          end
          default: begin
            addr_ok = 1'b0;
          end
        endcase
      end
    end
  end

  // Every transfer gets exactly one wait state, which also lets a just-issued instruction settle before reads.
  assign apb_access = psel_i & penable_i;
  assign apb_capture = apb_access & ~pready_r;
  assign apb_fire = apb_access & pready_r;
  assign wr_fire = apb_fire & pwrite_i & ~pslverr_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= apb_capture;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (apb_capture) begin
      prdata_r <= pwrite_i ? '0 : rd_mux;
      pslverr_r <= ~addr_ok;
    end else if (apb_fire) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // Instruction word and the one-cycle execute request.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      instr_r <= '0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (wr_fire && !addr_gpr && paddr_i == OFF_INSTR) begin
        instr_r <= merge_strb(instr_r, pwdata_i, pstrb_i);
        go_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_r <= PC_RST;
    end else if (go_r) begin
      pc_r <= pc_nxt;
    end else if (wr_fire && !addr_gpr && paddr_i == OFF_PC) begin
      pc_r <= merge_strb(pc_r, pwdata_i, pstrb_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_r <= STATUS_RST;
    end else if (go_r) begin
      status_r <= status_nxt;
    end else if (wr_fire && !addr_gpr && paddr_i == OFF_STATUS && pstrb_i[0]) begin
      status_r <= pwdata_i[STATUS_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bstatus_r <= STATUS_RST;
    end else if (go_r) begin
      bstatus_r <= bstatus_nxt;
    end else if (wr_fire && !addr_gpr && paddr_i == OFF_BSTATUS && pstrb_i[0]) begin
      bstatus_r <= pwdata_i[STATUS_W-1:0];
    end
  end

  // Execution owns the write port in its cycle; a bus write cannot complete in that same cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NREGS; i++) begin
        gpr_r[i] <= '0;
      end
    end else if (res_we) begin
      gpr_r[res_idx] <= res_data;
    end else if (wr_fire && addr_gpr) begin
      gpr_r[addr_gpr_idx] <= merge_strb(gpr_r[addr_gpr_idx], pwdata_i, pstrb_i);
    end
  end

  // Unsupported flag is write-one-to-clear; a new event in the same cycle keeps it set.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      unsup_r <= 1'b0;
    end else if (res_unsup) begin
      unsup_r <= 1'b1;
    end else if (wr_fire && !addr_gpr && paddr_i == OFF_EXEC && pstrb_i[0] && pwdata_i[EX_UNSUP]) begin
      unsup_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      taken_r <= 1'b0;
      exec_cnt_r <= '0;
    end else if (go_r) begin
      taken_r <= res_taken;
      exec_cnt_r <= exec_cnt_r + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [tb/bce_exec_properties.sv]
// Port-level checker for the branch, call and compare execution block.
`timescale 1ns/100ps
`default_nettype none
module bce_exec_properties import bce_pkg::*; #(
  parameter logic [XLEN-1:0] BREAK_HANDLER_ADDR = 32'h0000_0020
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [XLEN-1:0] pwdata_i,
  input wire logic [STRB_W-1:0] pstrb_i,
  input wire logic [XLEN-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  logic brk_r;
  logic done_w;
  assign done_w = psel_i && penable_i && pready_o;
  // Remembers that the last instruction word written was a trap, until software rewrites the PC or status.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      brk_r <= 1'b0;
    end else if (done_w && pwrite_i && paddr_i == OFF_INSTR) begin
      brk_r <= (pwdata_i[5:0] == OP_RTYPE) && (pwdata_i[16:11] == OPX_BREAK);
    end else if (done_w && pwrite_i && (paddr_i == OFF_PC || paddr_i == OFF_STATUS)) begin
      brk_r <= 1'b0;
    end
  end
  one_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not given after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside a completion");
  wdata_quiet_a: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0000_0000)
    else $error("read data driven during a write");
  unaligned_err_a: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("unaligned access not refused");
  zero_reg_a: assert property (pready_o && !pwrite_i && paddr_i == 8'h80 |-> prdata_o == 32'h0000_0000)
    else $error("register zero read nonzero");
  handler_const_a: assert property (pready_o && !pwrite_i && paddr_i == OFF_PC && brk_r |-> prdata_o == BREAK_HANDLER_ADDR)
    else $error("trap did not land on handler");
  trap_mask_a: assert property (pready_o && !pwrite_i && paddr_i == OFF_STATUS && brk_r |-> prdata_o[1:0] == 2'h0)
    else $error("trap left enable or user bit set");
endmodule
bind bce_exec_top bce_exec_properties #(.BREAK_HANDLER_ADDR(BREAK_HANDLER_ADDR)) i_bce_exec_properties (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o));
`default_nettype wire

// [tb/bce_exec_top_bench.sv]
// Self-checking testbench driving the execution block over its register bus.
`timescale 1ns/100ps
`default_nettype none
module bce_exec_top_bench;
  import bce_pkg::*;
  localparam logic [XLEN-1:0] BRK = 32'h0000_0a40;
  localparam logic [OP_W-1:0] EQI = 6'h20;
  localparam logic [OP_W-1:0] GEI = 6'h08;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  int failures, checks, cyc;
  bce_exec_top #(.BREAK_HANDLER_ADDR(BRK), .OP_CMPEQI_CODE(EQI), .OP_CMPGEI_CODE(GEI)) i_bce_exec_top (
    .clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hung transfer would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  function automatic logic [7:0] ga(input logic [4:0] i);
    return {1'b1, i, 2'h0};
  endfunction
  function automatic logic [31:0] ei(input logic [4:0] a, input logic [4:0] b, input logic [15:0] m,
                                     input logic [5:0] o);
    return {a, b, m, o};
  endfunction
  function automatic logic [31:0] er(input logic [4:0] a, input logic [4:0] b, input logic [4:0] c,
                                     input logic [5:0] x, input logic [4:0] s);
    return {a, b, c, x, s, OP_RTYPE};
  endfunction
  task automatic t_reset();
    rd(OFF_INSTR, 32'h0000_0000);
    rd(OFF_PC, PC_RST);
    rd(OFF_STATUS, 32'h0000_0000);
    rd(OFF_BSTATUS, 32'h0000_0000);
    rd(OFF_EXEC, 32'h0000_0000);
    wr(ga(5'h00), 32'h0000_ffff);
    rd(ga(5'h00), 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("reset test done");
  endtask
  task automatic t_branch();
    wr(ga(5'h01), 32'h0000_0005);
    wr(ga(5'h02), 32'h0000_0007);
    wr(OFF_PC, 32'h0000_0100);
    wr(OFF_INSTR, ei(5'h01, 5'h02, 16'hfff8, OP_BNE));
    rd(OFF_PC, 32'h0000_00fc);
    wr(ga(5'h02), 32'h0000_0005);
    wr(OFF_INSTR, ei(5'h01, 5'h02, 16'hfff8, OP_BNE));
    rd(OFF_PC, 32'h0000_0100);
    wr(OFF_PC, 32'h0000_0200);
    wr(OFF_INSTR, ei(5'h00, 5'h00, 16'h0040, OP_RELJMP));
    rd(OFF_PC, 32'h0000_0244);
    $display("branch test done");
  endtask
  task automatic t_trap();
    wr(OFF_STATUS, 32'h0000_0003);
    wr(OFF_PC, 32'h0000_0300);
    wr(OFF_INSTR, er(5'h00, 5'h00, BA_IDX, OPX_BREAK, 5'h1f));
    rd(OFF_BSTATUS, 32'h0000_0003);
    rd(ga(BA_IDX), 32'h0000_0304);
    rd(OFF_STATUS, 32'h0000_0000);
    rd(OFF_PC, BRK);
    wr(ga(BA_IDX), 32'h0000_05c0);
    wr(OFF_INSTR, er(BA_IDX, 5'h00, 5'h00, OPX_BRET, 5'h00));
    rd(OFF_STATUS, 32'h0000_0003);
    rd(OFF_PC, 32'h0000_05c0);
    $display("trap test done");
  endtask
  task automatic t_call();
    wr(OFF_PC, 32'h7000_0010);
    wr(OFF_INSTR, {26'h0123456, OP_CALL});
    rd(ga(RETADDR_IDX), 32'h7000_0014);
    rd(OFF_PC, {4'h7, 26'h0123456, 2'h0});
    wr(ga(RETADDR_IDX), 32'h0000_0800);
    wr(OFF_PC, 32'h0000_0400);
    wr(OFF_INSTR, er(RETADDR_IDX, 5'h00, RETADDR_IDX, OPX_CALLR, 5'h00));
    rd(OFF_PC, 32'h0000_0800);
    rd(ga(RETADDR_IDX), 32'h0000_0404);
    $display("call test done");
  endtask
  // The destination is preset to a value that neither outcome can produce.
  task automatic cmp1(input logic [31:0] ins, input logic [4:0] d, input logic [31:0] exp);
    wr(ga(d), 32'haaaa_aaaa);
    wr(OFF_INSTR, ins);
    rd(ga(d), exp);
  endtask
  task automatic t_compare();
    wr(ga(5'h04), 32'hffff_fffb);
    wr(ga(5'h05), 32'h0000_0003);
    cmp1(er(5'h04, 5'h05, 5'h06, OPX_CMPGE, 5'h00), 5'h06, 32'h0000_0000);
    cmp1(er(5'h05, 5'h04, 5'h06, OPX_CMPGE, 5'h00), 5'h06, 32'h0000_0001);
    cmp1(er(5'h04, 5'h04, 5'h06, OPX_CMPGE, 5'h00), 5'h06, 32'h0000_0001);
    cmp1(er(5'h04, 5'h05, 5'h06, OPX_CMPEQ, 5'h00), 5'h06, 32'h0000_0000);
    cmp1(er(5'h04, 5'h04, 5'h06, OPX_CMPEQ, 5'h00), 5'h06, 32'h0000_0001);
    cmp1(ei(5'h04, 5'h07, 16'hfffb, EQI), 5'h07, 32'h0000_0001);
    cmp1(ei(5'h04, 5'h07, 16'h0005, EQI), 5'h07, 32'h0000_0000);
    cmp1(ei(5'h05, 5'h07, 16'hfff0, GEI), 5'h07, 32'h0000_0001);
    cmp1(ei(5'h04, 5'h07, 16'h0003, GEI), 5'h07, 32'h0000_0000);
    cmp1(ei(5'h04, 5'h07, 16'hfffb, GEI), 5'h07, 32'h0000_0001);
    $display("compare test done");
  endtask
  // Unaligned refusal, unsupported opcode, sticky clear, flow flag, count and byte strobes.
  task automatic t_exec();
    logic [7:0] n;
    rd(8'h06, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    xfer(1'b0, OFF_EXEC, 32'h0000_0000);
    n = q[15:8];
    wr(OFF_PC, 32'h0000_0100);
    wr(OFF_INSTR, ei(5'h00, 5'h00, 16'h0000, 6'h3f));
    rd(OFF_PC, 32'h0000_0104);
    rd(OFF_EXEC, {16'h0, n + 8'h01, 8'h01});
    pstrb <= 4'h1;
    wr(OFF_PC, 32'hffff_ff08);
    wr(OFF_EXEC, 32'h0000_0001);
    pstrb <= 4'hf;
    rd(OFF_PC, 32'h0000_0108);
    rd(OFF_EXEC, {16'h0, n + 8'h01, 8'h00});
    wr(OFF_INSTR, ei(5'h00, 5'h00, 16'h0000, OP_RELJMP));
    rd(OFF_PC, 32'h0000_010c);
    rd(OFF_EXEC, {16'h0, n + 8'h02, 8'h02});
    $display("exec status test done");
  endtask
  initial begin
    failures = 0;
    checks = 0;
    cyc = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_branch();
    t_trap();
    t_call();
    t_compare();
    t_exec();
    end_sim();
  end
endmodule
`default_nettype wire
